// File: bench/rsf_top_tb.sv
// Self-checking bench for the radio control and offset configuration.
// Assumes the design files under rtl/ are compiled before this one.
`timescale 1ns/10ps

module rsf_top_tb;
  // ==========================================================
  // Design connections
  logic                         clk_sys_in = 1'b0;
  logic                         nrst_in    = 1'b0;
  logic [7:0]                   addr = 8'h00, wdata = 8'h00, rdata;
  logic                         wr = 1'b0, rd = 1'b0, strobe = 1'b0;
  rsf_pkg::rsf_radio_state_type state = rsf_pkg::rsf_st_idle;
  logic                         osc_pin = 1'b0, carrier = 1'b0;
  logic                         sync = 1'b0, valid = 1'b0;
  logic signed [7:0]            err = 8'sh00;
  logic                         cal, rdy_n, pin_on, osc_en, freeze;
  logic signed [10:0]           ofs;
  int                           err_count = 0, n_checks = 0;
  int                           n_cal = 0, cycles = 0;

  rsf_top DUT (
    .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .reg_addr_in(addr),
    .reg_wr_data_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rd_data_out(rdata), .radio_state_in(state),
    .synth_calibrate_strobe_in(strobe), .osc_stable_pin_in(osc_pin),
    .synth_cal_start_out(cal), .chip_ready_n_out(rdy_n),
    .pin_radio_ctrl_on_out(pin_on), .osc_enable_out(osc_en),
    .carrier_detect_flag_in(carrier), .sync_word_found_in(sync),
    .freq_err_valid_in(valid), .freq_err_in(err),
    .loop_freeze_out(freeze), .freq_offset_out(ofs));

  // ==========================================================
  // Clock, calibration pulse counter and hang guard
  always #5 clk_sys_in = ~clk_sys_in;

  // Counting pulses here lets each scenario judge totals, not timing.
  always @(posedge clk_sys_in) begin
    cycles <= cycles + 1;
    if (cal === 1'b1) n_cal <= n_cal + 1;
    if (cycles == 30000) begin
      err_count++;
      complete_run();
    end
  end

  // ==========================================================
  // Shared tasks
  task automatic complete_run();
    if (err_count == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Settles one edge's updates before anything is sampled.
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk_sys_in);
      #1;
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_sys_in);
    wr    <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys_in);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_sys_in);
    rd   <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_regs();
    rd_chk(8'h18, 8'h04);
    rd_chk(8'h19, 8'h36);
    rd_chk(8'h2a, 8'h00);
    wr_reg(8'h18, 8'hff);
    rd_chk(8'h18, 8'h3f);
    chk(pin_on, 1'b1);
    wr_reg(8'h19, 8'hc0);
    rd_chk(8'h19, 8'h00);
    wr_reg(8'h19, 8'h36);
  endtask

  // The same walk runs under every setting; only the pulse total moves.
  task automatic t_cal();
    rsf_pkg::rsf_radio_state_type seq [10];
    int exp [4];
    int base;
    seq = '{rsf_pkg::rsf_st_rx, rsf_pkg::rsf_st_idle, rsf_pkg::rsf_st_tx,
            rsf_pkg::rsf_st_idle, rsf_pkg::rsf_st_rx, rsf_pkg::rsf_st_idle,
            rsf_pkg::rsf_st_synth_tx_ready_state, rsf_pkg::rsf_st_idle,
            rsf_pkg::rsf_st_rx, rsf_pkg::rsf_st_idle};
    exp = '{1, 6, 5, 2};
    for (int m = 0; m < 4; m++) begin
      wr_reg(8'h18, {2'h0, m[1:0], 4'h4});
      tick(2);
      base = n_cal;
      for (int i = 0; i < 10; i++) begin
        @(posedge clk_sys_in) state <= seq[i];
        tick(3);
      end
      @(posedge clk_sys_in) strobe <= 1'b1;
      @(posedge clk_sys_in) strobe <= 1'b0;
      tick(3);
      chk(n_cal - base, exp[m]);
    end
  endtask

  // Every expire setting runs; the longest wait dominates the run time.
  task automatic t_power();
    int cnt;
    int n_exp [4];
    n_exp = '{1, 16, 64, 256};
    for (int s = 0; s < 4; s++) begin
      wr_reg(8'h18, {4'h0, s[1:0], 2'h0});
      @(posedge clk_sys_in) osc_pin <= 1'b1;
      for (cnt = 0; cnt < 20000 && rdy_n !== 1'b0; cnt++) tick(1);
      chk(cnt >= 64 * n_exp[s] && cnt <= 64 * n_exp[s] + 8,
          1'b1);
      @(posedge clk_sys_in) osc_pin <= 1'b0;
      tick(4);
      chk(rdy_n, 1'b1);
    end
  endtask

  // One error sample, then two edges for the offset to settle.
  task automatic err_pulse(input logic signed [7:0] e);
    @(posedge clk_sys_in) {valid, err} <= {1'b1, e};
    @(posedge clk_sys_in) valid <= 1'b0;
    tick(2);
  endtask

  task automatic t_offset();
    wr_reg(8'h19, 8'h37);
    @(posedge clk_sys_in) state <= rsf_pkg::rsf_st_rx;
    tick(3);
    chk(freeze, 1'b1);
    err_pulse(8'sh01);
    chk(ofs, 11'h000);
    @(posedge clk_sys_in) carrier <= 1'b1;
    tick(3);
    chk(freeze, 1'b0);
    err_pulse(8'sh01);
    chk(ofs, 11'h003);
    @(posedge clk_sys_in) sync <= 1'b1;
    tick(2);
    err_pulse(8'sh02);
    chk(ofs, 11'h004);
    wr_reg(8'h19, 8'h35);
    err_pulse(8'sh7f);
    chk(ofs, 11'h040);
    wr_reg(8'h19, 8'h34);
    tick(2);
    chk(ofs, 11'h000);
    @(posedge clk_sys_in) begin
      state   <= rsf_pkg::rsf_st_idle;
      carrier <= 1'b0;
      sync    <= 1'b0;
    end
  endtask

  task automatic t_osc();
    wr_reg(8'h18, 8'h00);
    @(posedge clk_sys_in) state <= rsf_pkg::rsf_st_sleep;
    tick(4);
    chk(osc_en, 1'b0);
    wr_reg(8'h18, 8'h01);
    tick(4);
    chk(osc_en, 1'b1);
    chk(pin_on, 1'b0);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (2) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    t_regs();
    t_cal();
    t_power();
    t_offset();
    t_osc();
    complete_run();
  end
endmodule

// File: rtl/rsf_defines.svh
// Offsets, field positions, reset values and counts of the radio
// control and offset compensation configuration registers.
// Assumes an 8-bit register port; included by the power-up timer and the top design file.
`ifndef RSF_DEFINES_SVH
`define RSF_DEFINES_SVH

// ==========================================================
// Register offsets and storage width
`define RSF_RADIO_CTRL_OFS   8'h18
`define RSF_FOC_CFG_OFS      8'h19
`define RSF_CFG_W            6

// ==========================================================
// Field positions of the radio control register
`define RSF_AUTOCAL_LSB      4
`define RSF_PO_LSB           2
`define RSF_PIN_CTRL_BIT     1
`define RSF_KEEP_OSC_BIT     0

// ==========================================================
// Field positions of the offset compensation register
`define RSF_CS_GATE_BIT      5
`define RSF_PRE_K_LSB        3
`define RSF_POST_K_BIT       2
`define RSF_LIMIT_LSB        0

// ==========================================================
// Reset values, reserved bits excluded
`define RSF_RADIO_CTRL_RST   6'h04
`define RSF_FOC_CFG_RST      6'h36

// ==========================================================
// Power-up timing: six-bit ripple counter and expire counts; last count of the every-fourth calibration
`define RSF_RIPPLE_W         6
`define RSF_EXPIRE_0         9'h001
`define RSF_EXPIRE_1         9'h010
`define RSF_EXPIRE_2         9'h040
`define RSF_EXPIRE_3         9'h100
`define RSF_CAL_EVERY_LAST   2'h3

`endif

// File: rtl/rsf_pkg.sv
// Types shared by the configuration block and its power-up timer.
// Assumes nothing of its surroundings.
package rsf_pkg;

  // ========================================================
  // Radio states reported by the main state machine, Gray coded.
  typedef enum logic [2:0] {
    rsf_st_sleep  = 3'h0,
    rsf_st_idle   = 3'h1,
    rsf_st_rx     = 3'h3,
    rsf_st_tx     = 3'h2,
    rsf_st_synth_tx_ready_state = 3'h6
  } rsf_radio_state_type;

  // ========================================================
  // Automatic synthesizer calibration settings.
  typedef enum logic [1:0] {
    rsf_cal_never    = 2'h0,
    rsf_cal_on_start = 2'h1,
    rsf_cal_on_end   = 2'h2,
    rsf_cal_every4   = 2'h3
  } rsf_autocal_type;

  // ========================================================
  // Power-up timer states, Gray coded.
  typedef enum logic [1:0] {
    rsf_po_off   = 2'h0,
    rsf_po_count = 2'h1,
    rsf_po_ready = 2'h3
  } rsf_po_state_type;

endpackage

// File: rtl/rsf_po_timer.sv
// Power-up delay that holds chip ready off until the ripple counter
// has expired the selected number of times.
// Assumes the crystal clock and an already synchronised stable flag.
`timescale 1ns/10ps
`include "rsf_defines.svh"

module rsf_po_timer (
  // Clock and reset.
  input  wire logic       clk_sys_in,
  input  wire logic       nrst_in,
  // Oscillator status and expire selection.
  input  wire logic       osc_stable_in,
  input  wire logic [1:0] expire_sel_in,
  // Chip ready, active low.
  output logic            chip_ready_n_out
);

  // ========================================================
  // State and counters
  rsf_pkg::rsf_po_state_type  state;
  logic [`RSF_RIPPLE_W-1:0]   ripple;
  logic [8:0]                 expiries;
  logic                       done;
  logic [14:0]                dwell;

  // Expire count for each selection setting.
  function automatic logic [8:0] expire_count(input logic [1:0] sel);
    unique case (sel)
      2'h0: expire_count = `RSF_EXPIRE_0;
      2'h1: expire_count = `RSF_EXPIRE_1;
      2'h2: expire_count = `RSF_EXPIRE_2;
      2'h3: expire_count = `RSF_EXPIRE_3;
    endcase
  endfunction

  // Last cycle of the last selected expiry.
  assign done = (state == rsf_pkg::rsf_po_count) && (&ripple) &&
    (expiries == expire_count(expire_sel_in) - 9'h001);

  // ========================================================
  // Sequencer; losing the oscillator always restarts the wait.
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state <= rsf_pkg::rsf_po_off;
    end else if (!osc_stable_in) begin
      state <= rsf_pkg::rsf_po_off;
    end else begin
      unique case (state)
        rsf_pkg::rsf_po_off:   state <= rsf_pkg::rsf_po_count;
        rsf_pkg::rsf_po_count: begin
          if (done) begin
            state <= rsf_pkg::rsf_po_ready;
          end
        end
        rsf_pkg::rsf_po_ready: state <= rsf_pkg::rsf_po_ready;
        default:               state <= rsf_pkg::rsf_po_off;
      endcase
    end
  end

  // Ripple counter and its expiry count, cleared outside the wait.
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ripple   <= '0;
      expiries <= '0;
    end else if (state != rsf_pkg::rsf_po_count) begin
      ripple   <= '0;
      expiries <= '0;
    end else begin
      ripple <= ripple + 6'h01;
      if (&ripple) begin
        expiries <= expiries + 9'h001;
      end
    end
  end

  // Chip ready falls on the same edge as the sequencer reaches ready.
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      chip_ready_n_out <= 1'b1;
    end else begin
      chip_ready_n_out <= !(osc_stable_in &&
        (done || state == rsf_pkg::rsf_po_ready));
    end
  end

  // ========================================================
  // Checks; the dwell counter only serves them.
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      dwell <= '0;
    end else if (state == rsf_pkg::rsf_po_count) begin
      dwell <= dwell + 15'h0001;
    end else begin
      dwell <= '0;
    end
  end

  property p_po_wait;
    @(posedge clk_sys_in) disable iff (!nrst_in)
    $fell(chip_ready_n_out) && $stable(expire_sel_in) |->
      dwell == {expire_count(expire_sel_in), 6'h00};
  endproperty
  a_po_wait: assert property (p_po_wait)
    else $error("Chip ready fell after the wrong number of cycles.");

  property p_po_drop;
    @(posedge clk_sys_in) disable iff (!nrst_in)
    !osc_stable_in |=> chip_ready_n_out [*2];
  endproperty
  a_po_drop: assert property (p_po_drop)
    else $error("Chip ready asserted without a stable oscillator.");

endmodule

// File: rtl/rsf_top.sv
// Radio control and frequency offset compensation configuration, with
// the calibration triggers, power-up delay and offset loop they steer.
// Assumes one crystal clock; radio state and demodulator flags come
// from logic on the same clock, the oscillator flag from analog.
//
// Implementation choice: the plain strobed port.
`timescale 1ns/10ps
`include "rsf_defines.svh"

module rsf_top #(
  parameter int ERR_W   = 8,
  parameter int OFS_W   = 11,
  parameter int BW_FULL = 512
) (
  // Clock and reset.
  input  wire logic                   clk_sys_in,
  input  wire logic                   nrst_in,
  // Register port.
  input  wire logic [7:0]             reg_addr_in,
  input  wire logic [7:0]             reg_wr_data_in,
  input  wire logic                   reg_wr_in,
  input  wire logic                   reg_rd_in,
  output logic [7:0]                  reg_rd_data_out,
  // Radio control.
  input  rsf_pkg::rsf_radio_state_type radio_state_in,
  input  wire logic                   synth_calibrate_strobe_in,
  input  wire logic                   osc_stable_pin_in,
  output logic                        synth_cal_start_out,
  output logic                        chip_ready_n_out,
  output logic                        pin_radio_ctrl_on_out,
  output logic                        osc_enable_out,
  // Frequency offset compensation.
  input  wire logic                   carrier_detect_flag_in,
  input  wire logic                   sync_word_found_in,
  input  wire logic                   freq_err_valid_in,
  input  wire logic signed [ERR_W-1:0] freq_err_in,
  output logic                        loop_freeze_out,
  output logic signed [OFS_W-1:0]     freq_offset_out
);

  // ========================================================
  // Widths of the loop arithmetic
  localparam int ACC_W  = OFS_W + 1;
  localparam int STEP_W = ERR_W + 5;
  localparam int SUM_W  = (ACC_W > STEP_W ? ACC_W : STEP_W) + 1;

  // ========================================================
  // Declarations
  logic [`RSF_CFG_W-1:0]        radio_control_config;
  logic [`RSF_CFG_W-1:0]        freq_offset_comp_config;
  rsf_pkg::rsf_autocal_type     autocal_mode;
  rsf_pkg::rsf_radio_state_type prev_state;
  logic                         start_evt;
  logic                         end_evt;
  logic [1:0]                   end_count;
  logic                         next_cal;
  logic                         osc_meta;
  logic                         osc_sync;
  logic                         in_rx;
  logic                         cs_seen;
  logic                         next_cs_seen;
  logic                         sync_seen;
  logic                         synced;
  logic                         cs_gate;
  logic [1:0]                   pre_sel;
  logic                         post_sel;
  logic [1:0]                   lim_sel;
  logic [3:0]                   gain;
  logic [ACC_W-1:0]             lim;
  logic signed [STEP_W-1:0]     step;
  logic signed [SUM_W-1:0]      base;
  logic signed [SUM_W-1:0]      lim_s;
  logic signed [ACC_W-1:0]      acc;
  logic signed [ACC_W-1:0]      next_acc;

  // ========================================================
  // Functions
  // States that leave IDLE towards the synthesizer running.
  function automatic logic is_active(
    input rsf_pkg::rsf_radio_state_type s);
    is_active = (s == rsf_pkg::rsf_st_rx) ||
                (s == rsf_pkg::rsf_st_tx) ||
                (s == rsf_pkg::rsf_st_synth_tx_ready_state);
  endfunction

  // Receive or transmit only.
  function automatic logic is_rxtx(
    input rsf_pkg::rsf_radio_state_type s);
    is_rxtx = (s == rsf_pkg::rsf_st_rx) || (s == rsf_pkg::rsf_st_tx);
  endfunction

  // Loop gain in units of K/2.
  function automatic logic [3:0] gain_half(input logic [1:0] pre,
                                           input logic       post,
                                           input logic       sw);
    if (sw && post) begin
      gain_half = 4'h1;
    end else begin
      gain_half = {1'b0, pre, 1'b0} + 4'h2;
    end
  endfunction

  // Saturation point in units of half an offset step.
  function automatic logic [ACC_W-1:0] lim_half(input logic [1:0] sel);
    unique case (sel)
      2'h0: lim_half = '0;
      2'h1: lim_half = ACC_W'(BW_FULL / 4);
      2'h2: lim_half = ACC_W'(BW_FULL / 2);
      2'h3: lim_half = ACC_W'(BW_FULL);
    endcase
  endfunction

  // ========================================================
  // Register writes; only the six low bits are stored.
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      radio_control_config <= `RSF_RADIO_CTRL_RST;
    end else if (reg_wr_in && reg_addr_in == `RSF_RADIO_CTRL_OFS) begin
      radio_control_config <= reg_wr_data_in[`RSF_CFG_W-1:0];
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      freq_offset_comp_config <= `RSF_FOC_CFG_RST;
    end else if (reg_wr_in && reg_addr_in == `RSF_FOC_CFG_OFS) begin
      freq_offset_comp_config <= reg_wr_data_in[`RSF_CFG_W-1:0];
    end
  end

  // Read data stand for exactly one cycle; unmapped reads give zero.
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      reg_rd_data_out <= 8'h00;
    end else if (reg_rd_in) begin
      unique case (reg_addr_in)
        `RSF_RADIO_CTRL_OFS:
          reg_rd_data_out <= {2'b00, radio_control_config};
        `RSF_FOC_CFG_OFS:
          reg_rd_data_out <= {2'b00, freq_offset_comp_config};
        default: reg_rd_data_out <= 8'h00;
      endcase
    end else begin
      reg_rd_data_out <= 8'h00;
    end
  end

  // ========================================================
  // Field decode.
  assign autocal_mode = rsf_pkg::rsf_autocal_type'(
    radio_control_config[`RSF_AUTOCAL_LSB +: 2]);
  assign cs_gate  = freq_offset_comp_config[`RSF_CS_GATE_BIT];
  assign pre_sel  = freq_offset_comp_config[`RSF_PRE_K_LSB +: 2];
  assign post_sel = freq_offset_comp_config[`RSF_POST_K_BIT];
  assign lim_sel  = freq_offset_comp_config[`RSF_LIMIT_LSB +: 2];
  assign pin_radio_ctrl_on_out =
    radio_control_config[`RSF_PIN_CTRL_BIT];

  // ========================================================
  // Calibration triggers.
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      prev_state <= rsf_pkg::rsf_st_sleep;
    end else begin
      prev_state <= radio_state_in;
    end
  end

  assign start_evt = (prev_state == rsf_pkg::rsf_st_idle) &&
                     is_active(radio_state_in);
  assign end_evt = is_rxtx(prev_state) &&
                   (radio_state_in == rsf_pkg::rsf_st_idle);

  // Returns to IDLE are counted only in the every-fourth setting, so a
  // change of setting always starts a fresh group of four.
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      end_count <= 2'h0;
    end else if (autocal_mode != rsf_pkg::rsf_cal_every4) begin
      end_count <= 2'h0;
    end else if (end_evt) begin
      end_count <= end_count + 2'h1;
    end
  end

  // The manual strobe calibrates in every setting.
  always_comb begin
    next_cal = synth_calibrate_strobe_in;
    unique case (autocal_mode)
      rsf_pkg::rsf_cal_never: ;
      rsf_pkg::rsf_cal_on_start:
        next_cal = next_cal || start_evt;
      rsf_pkg::rsf_cal_on_end:
        next_cal = next_cal || end_evt;
      rsf_pkg::rsf_cal_every4:
        next_cal = next_cal || (end_evt &&
          end_count == `RSF_CAL_EVERY_LAST);
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      synth_cal_start_out <= 1'b0;
    end else begin
      synth_cal_start_out <= next_cal;
    end
  end

  // ========================================================
  // Oscillator control and power-up delay.
  // The stable flag comes from the analog oscillator, so it is
  // synchronised before the timer looks at it.
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      osc_meta <= 1'b0;
      osc_sync <= 1'b0;
    end else begin
      osc_meta <= osc_stable_pin_in;
      osc_sync <= osc_meta;
    end
  end

  // Crystal runs outside SLEEP, and in SLEEP only when kept on.
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      osc_enable_out <= 1'b1;
    end else begin
      osc_enable_out <= (radio_state_in != rsf_pkg::rsf_st_sleep) ||
        radio_control_config[`RSF_KEEP_OSC_BIT];
    end
  end

  rsf_po_timer u_po_timer (
    .clk_sys_in       (clk_sys_in),
    .nrst_in          (nrst_in),
    .osc_stable_in    (osc_sync),
    .expire_sel_in    (radio_control_config[`RSF_PO_LSB +: 2]),
    .chip_ready_n_out (chip_ready_n_out)
  );

  // ========================================================
  // Offset loop gating: carrier and sync flags hold for one stay in RX.
  assign in_rx        = (radio_state_in == rsf_pkg::rsf_st_rx);
  assign next_cs_seen = in_rx && (cs_seen || carrier_detect_flag_in);
  assign synced       = sync_seen || sync_word_found_in;

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cs_seen   <= 1'b0;
      sync_seen <= 1'b0;
    end else begin
      cs_seen   <= next_cs_seen;
      sync_seen <= in_rx && synced;
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      loop_freeze_out <= 1'b1;
    end else begin
      loop_freeze_out <= cs_gate && !next_cs_seen;
    end
  end

  // ========================================================
  // Offset accumulator, kept in half steps so that K/2 stays exact.
  // Clamping every cycle makes a lowered limit take effect at once.
  assign gain  = gain_half(pre_sel, post_sel, synced);
  assign lim   = lim_half(lim_sel);
  assign lim_s = $signed(SUM_W'(lim));

  always_comb begin
    step = freq_err_in * $signed({1'b0, gain});
    if (freq_err_valid_in && !loop_freeze_out) begin
      base = SUM_W'(acc) + SUM_W'(step);
    end else begin
      base = SUM_W'(acc);
    end
    if (!in_rx || lim_sel == 2'h0) begin
      next_acc = '0;
    end else if (base > lim_s) begin
      next_acc = ACC_W'(lim_s);
    end else if (base < -lim_s) begin
      next_acc = ACC_W'(-lim_s);
    end else begin
      next_acc = ACC_W'(base);
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      acc             <= '0;
      freq_offset_out <= '0;
    end else begin
      acc             <= next_acc;
      freq_offset_out <= next_acc[ACC_W-1:1];
    end
  end

  // ========================================================
  // Checks
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!nrst_in);

  property p_no_autocal;
    autocal_mode == rsf_pkg::rsf_cal_never &&
    !synth_calibrate_strobe_in |=> !synth_cal_start_out;
  endproperty
  a_no_autocal: assert property (p_no_autocal)
    else $error("Calibration started without the strobe.");

  property p_cal_start;
    autocal_mode == rsf_pkg::rsf_cal_on_start && start_evt
      |=> synth_cal_start_out;
  endproperty
  a_cal_start: assert property (p_cal_start)
    else $error("No calibration when leaving IDLE.");

  property p_cal_end;
    autocal_mode == rsf_pkg::rsf_cal_on_end && end_evt
      |=> synth_cal_start_out;
  endproperty
  a_cal_end: assert property (p_cal_end)
    else $error("No calibration on return to IDLE.");

  property p_cal_every4;
    autocal_mode == rsf_pkg::rsf_cal_every4 && end_evt &&
    !synth_calibrate_strobe_in |=>
      synth_cal_start_out == ($past(end_count) == 2'h3);
  endproperty
  a_cal_every4: assert property (p_cal_every4)
    else $error("Every-fourth calibration out of step.");

  property p_reserved;
    $past(reg_rd_in) |-> reg_rd_data_out[7:6] == 2'b00;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("Reserved bits read nonzero.");

  property p_pin_ctrl;
    reg_wr_in && reg_addr_in == `RSF_RADIO_CTRL_OFS |=>
      pin_radio_ctrl_on_out == $past(reg_wr_data_in[1]);
  endproperty
  a_pin_ctrl: assert property (p_pin_ctrl)
    else $error("Pin control bit did not follow the write.");

  property p_sleep_osc;
    radio_state_in == rsf_pkg::rsf_st_sleep |=>
      osc_enable_out == $past(radio_control_config[0]);
  endproperty
  a_sleep_osc: assert property (p_sleep_osc)
    else $error("Oscillator state in SLEEP is wrong.");

  sequence s_wait_carrier;
    cs_gate && in_rx && !carrier_detect_flag_in && !cs_seen;
  endsequence
  sequence s_carrier_up;
    in_rx && carrier_detect_flag_in;
  endsequence
  property p_freeze;
    s_wait_carrier |=> loop_freeze_out;
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("Loops ran before carrier sense.");
  property p_thaw;
    s_carrier_up ##1 in_rx |-> !loop_freeze_out;
  endproperty
  a_thaw: assert property (p_thaw)
    else $error("Loops stayed frozen after carrier sense.");

  sequence s_unit_step;
    freq_err_valid_in && !loop_freeze_out && in_rx && acc == '0 &&
    freq_err_in == ERR_W'(1) && lim_sel == 2'h3;
  endsequence
  property p_gain;
    s_unit_step |=> acc == (($past(synced) && $past(post_sel)) ?
      ACC_W'(1) : ACC_W'(2 * $past(pre_sel) + 2));
  endproperty
  a_gain: assert property (p_gain)
    else $error("Loop gain does not match the setting.");

  property p_limit;
    1'b1 |=> acc <= $signed(ACC_W'($past(lim))) &&
             acc >= -$signed(ACC_W'($past(lim)));
  endproperty
  a_limit: assert property (p_limit)
    else $error("Offset exceeds the saturation point.");

endmodule
